// ---- hdl/escio_pkg.sv ----
// shared constants for the external scan control block
package escio_pkg;
   // timing
   localparam int CLK_KHZ = 125000;
   localparam int BOUNCE_MS = 30;
   localparam int MIN_PULSE_MS = 100;
   localparam int BOUNCE_CYCLES = BOUNCE_MS * CLK_KHZ;
   localparam int MIN_PULSE_CYCLES = MIN_PULSE_MS * CLK_KHZ;
   // contact input channels
   localparam int NUM_CONTACTS = 3;
   localparam int CH_START = 0;
   localparam int CH_SINGLE = 1;
   localparam int CH_SERVICE = 2;
   // register offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_INT_STAT = 8'h08;
   localparam logic [7:0] OFS_INT_MASK = 8'h0C;
   localparam logic [1:0] BANK_CTRL = 2'h0;
   localparam logic [1:0] BANK_HIGH = 2'h1;
   localparam logic [1:0] BANK_LOW = 2'h2;
   localparam int MAX_POINTS = 16;
   // control fields
   localparam int CTRL_PULSE_BIT = 0;
   localparam int CTRL_SRQ_EN_BIT = 1;
   localparam int CTRL_OVR_EN_BIT = 2;
   localparam int CTRL_OVR_VAL_BIT = 3;
   // status fields
   localparam int ST_RUN_BIT = 0;
   localparam int ST_SINGLE_BIT = 1;
   localparam int ST_ALARM_BIT = 2;
   localparam int ST_ERR_BIT = 3;
   localparam int ST_LEVEL_LSB = 4;
   // event fields
   localparam int NUM_EVENTS = 6;
   localparam int EV_START = 0;
   localparam int EV_STOP = 1;
   localparam int EV_SINGLE = 2;
   localparam int EV_DISCARD = 3;
   localparam int EV_SRQ = 4;
   localparam int EV_ALARM = 5;
   // reset values
   localparam logic [31:0] LIMIT_HIGH_RESET = 32'h7FFFFFFF;
   localparam logic [31:0] LIMIT_LOW_RESET = 32'h80000000;
   localparam logic [NUM_EVENTS-1:0] INT_MASK_RESET = 6'h00;
endpackage : escio_pkg

// ---- hdl/escio_debounce.sv ----
// contact synchroniser and debounce filter with rise detect
`timescale 1ns/1ns
module escio_debounce #(
   parameter int CYCLES = 3750000
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic contact,
   output logic level,
   output logic rise
);
   localparam int CW = $clog2(CYCLES + 1);

   if (CYCLES < 1)
   begin : g_bad_cycles
      $error("debounce window must be at least one cycle");
   end

   typedef struct packed {
      logic sync1;
      logic sync2;
      logic level;
      logic rise;
      logic [CW-1:0] cnt;
   } escio_deb_type;

   escio_deb_type s;
   escio_deb_type n;

   always_comb
   begin
      n = s;
      n.sync1 = contact;
      n.sync2 = s.sync1;
      n.rise = 1'b0;
      // level moves only after a full quiet window
      if (s.sync2 == s.level)
         n.cnt = '0;
      else if (s.cnt == CW'(CYCLES - 1))
      begin
         n.cnt = '0;
         n.level = s.sync2;
         n.rise = s.sync2;
      end
      else
         n.cnt = s.cnt + CW'(1);
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         s <= '0;
      else
         s <= n;
   end

   assign level = s.level;
   assign rise = s.rise;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   AST_DEB_RISE: assert property (rise |-> level && !$past(level)) // [R17]
      else $error("rise without a fresh high level");
endmodule : escio_debounce

// ---- hdl/escio_top.sv ----
// external scan control contacts, busy and alarm outputs, AHB-Lite registers
// Operation
// R1 - start input selectable level or pulse mode
// R2 - level mode: scan while contact closed
// R3 - pulse mode: each closure toggles scanning
// R4 - level mode ignores redundant start or stop
// R5 - single request: one closure, one scan
// R6 - single request discarded while scanning continuously
// R7 - service trigger closure raises one request
// R8 - service requests only when output enabled
// R9 - filter contact bounce up to 30ms
// R10 - accept closures of 100ms or more
// R11 - busy output low while log scanning
// R12 - alarm closes on limit overstep
// R13 - own high/low limit per point
// R14 - remote commands switch alarm contact
// R15 - single scans leave busy inactive
// R16 - sensor and processing errors close alarm
// R17 - sync, stable count, single rising event
`timescale 1ns/1ns
module escio_top #(
   parameter int NUM_POINTS = 8,
   parameter int BOUNCE_CYCLES = escio_pkg::BOUNCE_CYCLES,
   parameter int MIN_PULSE_CYCLES = escio_pkg::MIN_PULSE_CYCLES
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic start_contact,
   input wire logic single_contact,
   input wire logic service_trigger_input,
   input wire logic single_done,
   input wire logic meas_valid,
   input wire logic [$clog2(NUM_POINTS)-1:0] meas_point,
   input wire logic [31:0] meas_value,
   input wire logic [3:0] meas_error,
   output logic scan_run,
   output logic single_start,
   output logic service_request,
   output logic scan_busy_n,
   output logic alarm_contact,
   output logic irq
);
   localparam int PW = $clog2(NUM_POINTS);
   localparam int EN = escio_pkg::NUM_EVENTS;

   if (NUM_POINTS < 2 || NUM_POINTS > escio_pkg::MAX_POINTS)
   begin : g_bad_points
      $error("point count out of range");
   end
   if (BOUNCE_CYCLES < 1 || BOUNCE_CYCLES >= MIN_PULSE_CYCLES)
   begin : g_bad_window
      $error("bounce window must be shorter than the least pulse"); // [R9] [R10]
   end

   typedef struct packed {
      logic hreadyout;
      logic [31:0] hrdata;
      logic wr_pend;
      logic [7:0] wr_addr;
      logic pulse_mode;
      logic srq_en;
      logic ovr_en;
      logic ovr_val;
      logic run;
      logic single_busy;
      logic single_start;
      logic service_request;
      logic scan_busy_n;
      logic [NUM_POINTS-1:0] viol;
      logic err;
      logic alarm;
      logic [EN-1:0] ist;
      logic [EN-1:0] imask;
      logic irq;
      logic [NUM_POINTS-1:0][31:0] hi;
      logic [NUM_POINTS-1:0][31:0] lo;
   } escio_state_type;

   escio_state_type s;
   escio_state_type n;

   logic [escio_pkg::NUM_CONTACTS-1:0] contact_in;
   logic [escio_pkg::NUM_CONTACTS-1:0] deb_level;
   logic [escio_pkg::NUM_CONTACTS-1:0] deb_rise;

   assign contact_in = {service_trigger_input, single_contact, start_contact};

   // bounce window below the least pulse width, so every legal pulse survives
   for (genvar g = 0; g < escio_pkg::NUM_CONTACTS; g++)
   begin : g_contact
      escio_debounce #(
         .CYCLES(BOUNCE_CYCLES)
      ) u_deb (
         .hclk(hclk),
         .hresetn(hresetn),
         .contact(contact_in[g]),
         .level(deb_level[g]),
         .rise(deb_rise[g])
      ); // [R9] [R10] [R17]
   end

   function automatic logic [31:0] read_word(input escio_state_type st, input logic [7:0] a);
      logic [31:0] r;
      r = 32'h00000000;
      if (a[7:6] == escio_pkg::BANK_CTRL)
      begin
         unique case (a)
            escio_pkg::OFS_CTRL:
            begin
               r[escio_pkg::CTRL_PULSE_BIT] = st.pulse_mode;
               r[escio_pkg::CTRL_SRQ_EN_BIT] = st.srq_en;
               r[escio_pkg::CTRL_OVR_EN_BIT] = st.ovr_en;
               r[escio_pkg::CTRL_OVR_VAL_BIT] = st.ovr_val;
            end
            escio_pkg::OFS_STATUS:
            begin
               r[escio_pkg::ST_RUN_BIT] = st.run;
               r[escio_pkg::ST_SINGLE_BIT] = st.single_busy;
               r[escio_pkg::ST_ALARM_BIT] = st.alarm;
               r[escio_pkg::ST_ERR_BIT] = st.err;
               r[escio_pkg::ST_LEVEL_LSB +: escio_pkg::NUM_CONTACTS] = deb_level;
            end
            escio_pkg::OFS_INT_STAT: r[EN-1:0] = st.ist;
            escio_pkg::OFS_INT_MASK: r[EN-1:0] = st.imask;
            default: r = 32'h00000000;
         endcase
      end
      else
      begin
         for (int i = 0; i < NUM_POINTS; i++)
         begin
            if (a[5:2] == 4'(i) && a[7:6] == escio_pkg::BANK_HIGH)
               r = st.hi[i];
            if (a[5:2] == 4'(i) && a[7:6] == escio_pkg::BANK_LOW)
               r = st.lo[i];
         end
      end
      return r;
   endfunction : read_word

   always_comb
   begin
      logic [EN-1:0] ev;
      logic [EN-1:0] clr;
      logic scanning;
      ev = '0;
      clr = '0;
      scanning = 1'b0;
      n = s;
      n.single_start = 1'b0;
      n.service_request = 1'b0;
      n.hreadyout = 1'b1;

      // data phase of a write
      if (s.wr_pend)
      begin
         if (s.wr_addr == escio_pkg::OFS_CTRL)
         begin
            n.pulse_mode = hwdata[escio_pkg::CTRL_PULSE_BIT]; // [R1]
            n.srq_en = hwdata[escio_pkg::CTRL_SRQ_EN_BIT];
            n.ovr_en = hwdata[escio_pkg::CTRL_OVR_EN_BIT];
            n.ovr_val = hwdata[escio_pkg::CTRL_OVR_VAL_BIT];
         end
         if (s.wr_addr == escio_pkg::OFS_INT_STAT)
            clr = hwdata[EN-1:0];
         if (s.wr_addr == escio_pkg::OFS_INT_MASK)
            n.imask = hwdata[EN-1:0];
         for (int i = 0; i < NUM_POINTS; i++)
         begin
            if (s.wr_addr[5:2] == 4'(i) && s.wr_addr[7:6] == escio_pkg::BANK_HIGH)
               n.hi[i] = hwdata; // [R13]
            if (s.wr_addr[5:2] == 4'(i) && s.wr_addr[7:6] == escio_pkg::BANK_LOW)
               n.lo[i] = hwdata; // [R13]
         end
      end

      // address phase; zero wait states
      n.wr_pend = 1'b0;
      if (hsel && hready && htrans[1])
      begin
         n.wr_pend = hwrite;
         n.wr_addr = haddr[7:0];
         n.hrdata = hwrite ? 32'h00000000 : read_word(s, haddr[7:0]);
      end

      // continuous log scan control
      if (!s.pulse_mode)
      begin
         // redundant start while running or stop while idle falls through
         if (deb_level[escio_pkg::CH_START] && !s.run) // [R2] [R4]
         begin
            n.run = 1'b1;
            ev[escio_pkg::EV_START] = 1'b1;
         end
         else if (!deb_level[escio_pkg::CH_START] && s.run) // [R2] [R4]
         begin
            n.run = 1'b0;
            ev[escio_pkg::EV_STOP] = 1'b1;
         end
      end
      else if (deb_rise[escio_pkg::CH_START])
      begin
         n.run = !s.run; // [R3]
         ev[escio_pkg::EV_START] = !s.run;
         ev[escio_pkg::EV_STOP] = s.run;
      end

      // single scan: no queue, a busy engine drops the request
      if (single_done)
         n.single_busy = 1'b0;
      if (deb_rise[escio_pkg::CH_SINGLE])
      begin
         if (s.run || s.single_busy)
            ev[escio_pkg::EV_DISCARD] = 1'b1; // [R6]
         else
         begin
            n.single_start = 1'b1; // [R5]
            n.single_busy = 1'b1;
            ev[escio_pkg::EV_SINGLE] = 1'b1;
         end
      end

      // service request toward the host bus
      if (deb_rise[escio_pkg::CH_SERVICE] && s.srq_en) // [R7] [R8]
      begin
         n.service_request = 1'b1;
         ev[escio_pkg::EV_SRQ] = 1'b1;
      end

      // limit judgement; error flag restarts with each new scan
      if (ev[escio_pkg::EV_START] || ev[escio_pkg::EV_SINGLE])
         n.err = 1'b0;
      scanning = s.run || s.single_busy;
      if (meas_valid && scanning && 32'(meas_point) < 32'(NUM_POINTS))
      begin
         n.viol[meas_point] = ($signed(meas_value) > $signed(s.hi[meas_point])) ||
            ($signed(meas_value) < $signed(s.lo[meas_point])); // [R12] [R13]
         if (|meas_error)
            n.err = 1'b1; // [R16]
      end
      n.alarm = n.ovr_en ? n.ovr_val : (|n.viol || n.err); // [R12] [R14] [R16]
      if (n.alarm && !s.alarm)
         ev[escio_pkg::EV_ALARM] = 1'b1;

      n.scan_busy_n = !n.run; // [R11] [R15]
      // set beats a same-cycle clear
      n.ist = (s.ist & ~clr) | ev;
      n.irq = |(n.ist & n.imask);
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s <= '0;
         s.hreadyout <= 1'b1;
         s.scan_busy_n <= 1'b1;
         s.imask <= escio_pkg::INT_MASK_RESET;
         for (int i = 0; i < NUM_POINTS; i++)
         begin
            s.hi[i] <= escio_pkg::LIMIT_HIGH_RESET;
            s.lo[i] <= escio_pkg::LIMIT_LOW_RESET;
         end
      end
      else
         s <= n;
   end

   assign hreadyout = s.hreadyout;
   assign hresp = 1'b0;
   assign hrdata = s.hrdata;
   assign scan_run = s.run;
   assign single_start = s.single_start;
   assign service_request = s.service_request;
   assign scan_busy_n = s.scan_busy_n;
   assign alarm_contact = s.alarm;
   assign irq = s.irq;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   AST_LEVEL_FOLLOW: assert property (!s.pulse_mode && deb_level[0] && !scan_run |=> scan_run) // [R2]
      else $error("level mode did not start");
   AST_LEVEL_STOP: assert property (!s.pulse_mode && !deb_level[0] && scan_run |=> !scan_run) // [R2]
      else $error("level mode did not stop");
   AST_PULSE_TOGGLE: assert property (s.pulse_mode && deb_rise[0] |=> scan_run != $past(scan_run)) // [R3]
      else $error("pulse mode did not toggle");
   AST_SINGLE_ONCE: assert property (single_start |=> !single_start ##1 !single_start) // [R5]
      else $error("single start repeated");
   AST_SINGLE_DISCARD: assert property (deb_rise[1] && scan_run |=> !single_start) // [R6]
      else $error("single request not discarded");
   AST_SRQ_RAISE: assert property (deb_rise[2] && s.srq_en |=> service_request) // [R7]
      else $error("service request missing");
   AST_SRQ_GATE: assert property (service_request |-> $past(s.srq_en) && $past(deb_rise[2])) // [R8]
      else $error("service request while disabled");
   AST_BUSY: assert property (scan_busy_n == !scan_run) // [R11]
      else $error("busy output wrong");
   AST_SINGLE_NOBUSY: assert property (s.single_busy && !scan_run |-> scan_busy_n) // [R15]
      else $error("busy during single scan");
   AST_LIMIT: assert property (meas_valid && scan_run && !s.ovr_en && !single_done &&
      $signed(meas_value) > $signed(s.hi[meas_point]) |=> alarm_contact) // [R12] [R13]
      else $error("limit overstep without alarm");
   AST_ERR_ALARM: assert property (meas_valid && scan_run && |meas_error && !s.ovr_en |=> alarm_contact) // [R16]
      else $error("error without alarm");
   AST_REMOTE: assert property (s.ovr_en && $past(s.ovr_en) |-> alarm_contact == s.ovr_val) // [R14]
      else $error("remote alarm override ignored");
endmodule : escio_top

// ---- sim/escio_contact_model.sv ----
// bouncing dry-contact model for the external control inputs
`timescale 1ns/1ns
module escio_contact_model #(
   parameter int BOUNCE = 6
)
(
   input wire logic hclk,
   output logic contact
);
   initial contact = 1'b0;
   // chatter before settling, each burst shorter than the debounce window
   task automatic move(input logic v);
      for (int i = 0; i < BOUNCE; i++)
      begin
         @(posedge hclk);
         contact <= (i % 2 == 0) ? v : ~v;
      end
      @(posedge hclk);
      contact <= v;
   endtask : move
   // closure and gap each held for the minimum pulse width
   task automatic pulse(input int hold);
      move(1'b1);
      repeat (hold) @(posedge hclk);
      move(1'b0);
      repeat (hold) @(posedge hclk);
   endtask : pulse
endmodule : escio_contact_model

// ---- sim/escio_top_tb.sv ----
// self-checking bench for the external scan control block
`timescale 1ns/1ns
module escio_top_tb;
   localparam int HOLD = 40;
   localparam int SETTLE = 30;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, meas_value, rd;
   logic [1:0] htrans;
   logic [2:0] hsize, meas_point;
   logic [3:0] meas_error;
   logic start_c, single_c, service_c, single_done, meas_valid;
   logic scan_run, single_start, service_request, scan_busy_n, alarm_contact, irq;
   int errors = 0;
   int checked = 0;
   int n_single = 0;
   int n_srq = 0;
   assign hready = hreadyout;
   escio_top #(.NUM_POINTS(8), .BOUNCE_CYCLES(8), .MIN_PULSE_CYCLES(HOLD)) i_dut (.hclk(hclk),
      .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .start_contact(start_c), .single_contact(single_c), .service_trigger_input(service_c),
      .single_done(single_done), .meas_valid(meas_valid), .meas_point(meas_point),
      .meas_value(meas_value), .meas_error(meas_error), .scan_run(scan_run), .single_start(single_start),
      .service_request(service_request), .scan_busy_n(scan_busy_n), .alarm_contact(alarm_contact),
      .irq(irq));
   escio_contact_model i_start (.hclk(hclk), .contact(start_c));
   escio_contact_model i_single (.hclk(hclk), .contact(single_c));
   escio_contact_model i_srv (.hclk(hclk), .contact(service_c));
   initial
   begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end
   always @(posedge hclk)
   begin
      if (single_start === 1'b1) n_single++;
      if (service_request === 1'b1) n_srq++;
   end
   task automatic finish_test;
      $display("checked %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : finish_test
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   // address phase held until hready, then data phase held until hready
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(a, 1'b1, d);
      // the write and the outputs it drives land on the last edge of bus; wait one more edge before checking
      @(posedge hclk);
   endtask : wr
   task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
      bus(a, 1'b0, 32'h00000000);
      chk(name, exp, rd);
   endtask : rdc
   task automatic meas(input logic [2:0] p, input logic [31:0] v, input logic [3:0] e);
      @(posedge hclk);
      meas_valid <= 1'b1;
      meas_point <= p;
      meas_value <= v;
      meas_error <= e;
      @(posedge hclk);
      meas_valid <= 1'b0;
      meas_error <= 4'h0;
      repeat (3) @(posedge hclk);
   endtask : meas
   initial
   begin
      #200000;
      errors++;
      $display("[FAIL] watchdog expected end seen hang");
      finish_test();
   end
   initial
   begin
      {hsel, hwrite, single_done, meas_valid} = 4'h0;
      haddr = 32'h00000000;
      hwdata = 32'h00000000;
      htrans = 2'b00;
      hsize = 3'b010;
      meas_point = 3'h0;
      meas_value = 32'h00000000;
      meas_error = 4'h0;
      hresetn = 1'b0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      chk("busy_n", 32'h1, scan_busy_n);
      rdc("ctrl", escio_pkg::OFS_CTRL, 32'h00000000);
      chk("hresp", 32'h0, hresp);
      rdc("mask", escio_pkg::OFS_INT_MASK, 32'h00000000);
      rdc("high2", 8'h48, escio_pkg::LIMIT_HIGH_RESET);
      rdc("low7", 8'h9C, escio_pkg::LIMIT_LOW_RESET);
      wr(8'h30, 32'hFFFFFFFF);
      rdc("unmapped", 8'h30, 32'h00000000);
      wr(escio_pkg::OFS_STATUS, 32'hFFFFFFFF);
      rdc("status", escio_pkg::OFS_STATUS, 32'h00000000);
      $display("test reset done");
      wr(escio_pkg::OFS_INT_MASK, 32'h00000001);
      i_start.move(1'b1);
      repeat (SETTLE) @(posedge hclk);
      chk("run", 32'h1, scan_run);
      chk("busy_n", 32'h0, scan_busy_n);
      chk("irq", 32'h1, irq);
      i_single.pulse(HOLD);
      chk("single_cnt", 32'h0, n_single);
      rdc("int_stat", escio_pkg::OFS_INT_STAT, 32'h00000009);
      wr(escio_pkg::OFS_INT_STAT, 32'h00000001);
      rdc("int_stat", escio_pkg::OFS_INT_STAT, 32'h00000008);
      chk("irq", 32'h0, irq);
      meas(3'h3, 32'h000000C8, 4'h0);
      chk("alarm", 32'h0, alarm_contact);
      wr(8'h48, 32'h00000064);
      meas(3'h2, 32'h000000C8, 4'h0);
      chk("alarm", 32'h1, alarm_contact);
      wr(escio_pkg::OFS_CTRL, 32'h00000004);
      chk("alarm", 32'h0, alarm_contact);
      wr(escio_pkg::OFS_CTRL, 32'h0000000C);
      chk("alarm", 32'h1, alarm_contact);
      wr(escio_pkg::OFS_CTRL, 32'h00000000);
      chk("alarm", 32'h1, alarm_contact);
      meas(3'h2, 32'h00000032, 4'h0);
      chk("alarm", 32'h0, alarm_contact);
      meas(3'h5, 32'h00000000, 4'h4);
      chk("alarm", 32'h1, alarm_contact);
      rdc("status", escio_pkg::OFS_STATUS, 32'h0000001D);
      i_start.move(1'b0);
      repeat (SETTLE) @(posedge hclk);
      chk("run", 32'h0, scan_run);
      chk("busy_n", 32'h1, scan_busy_n);
      $display("test level done");
      i_single.pulse(HOLD);
      chk("single_cnt", 32'h1, n_single);
      chk("busy_n", 32'h1, scan_busy_n);
      @(posedge hclk);
      single_done <= 1'b1;
      @(posedge hclk);
      single_done <= 1'b0;
      $display("test single done");
      wr(escio_pkg::OFS_CTRL, 32'h00000001);
      i_start.pulse(HOLD);
      chk("run", 32'h1, scan_run);
      chk("busy_n", 32'h0, scan_busy_n);
      i_start.pulse(HOLD);
      chk("run", 32'h0, scan_run);
      $display("test pulse done");
      i_srv.pulse(HOLD);
      chk("srq_cnt", 32'h0, n_srq);
      wr(escio_pkg::OFS_CTRL, 32'h00000002);
      i_srv.pulse(HOLD);
      chk("srq_cnt", 32'h1, n_srq);
      $display("test service done");
      finish_test();
   end
endmodule : escio_top_tb
